// >>> logic/debug_probe_lock.v
// debug probe lock: gates the on-chip debug unit and probe flash reads
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "debug_probe_lock_map.vh"

module debug_probe_lock (
	// clock and resets
	input wire core_clk_i,
	input wire rst_n_i,
	input wire por_n_i,
	// register port
	input wire [31:0] addr_i,
	input wire [31:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [31:0] rdata_o,
	// probe pin and debug unit
	input wire probe_attach_i,
	input wire flash_rd_req_i,
	output wire flash_rd_grant_o,
	output wire flash_rd_refuse_o,
	output reg debug_unit_enable_o,
	output reg probe_active_o,
	output reg probe_lock_o
);

	// ======================================================================
	// decode
	wire hit_mode;
	wire hit_key;
	wire hit_status;
	wire wr_mode;
	wire wr_key;
	wire wr_status;
	wire key_ok;
	wire commit;

	// only the whole address is decoded; narrower accesses are not supported
	assign hit_mode = (addr_i == `DPL_ADDR_MODE);
	assign hit_key = (addr_i == `DPL_ADDR_KEY);
	assign hit_status = (addr_i == `DPL_ADDR_STATUS);
	assign wr_mode = wr_i & hit_mode;
	assign wr_key = wr_i & hit_key;
	assign wr_status = wr_i & hit_status;
	assign key_ok = (wdata_i == `DPL_PROTECT_CODE);
	assign commit = wr_key & key_ok;

	// ======================================================================
	// lock state, reset to locked only by power-on reset
	reg lock_q;
	reg lock_d;
	reg pend_disable_q;
	reg pend_reenable_q;

	always @* begin
		lock_d = lock_q;
		// the key commits whatever the last mode write staged
		if (commit) begin
			if (pend_reenable_q) begin
				lock_d = 1'b1;
			end else begin
				lock_d = pend_disable_q;
			end
		end
		// any other key value falls through unchanged
	end

	// power-on reset is the only reset that reaches the lock
	always @(posedge core_clk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			lock_q <= `DPL_MODE_RESET;
		end else begin
			lock_q <= lock_d;
		end
	end

	// ======================================================================
	// staged mode value, waits for the key
	// an ordinary reset stages a disable, so a key alone shuts the lock, even if it was open
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_disable_q <= 1'b1;
			pend_reenable_q <= 1'b0;
		end else if (wr_mode) begin
			pend_disable_q <= wdata_i[`DPL_MODE_DISABLE_BIT];
			pend_reenable_q <= wdata_i[`DPL_MODE_REENABLE_BIT];
		end else if (commit) begin
			// a committed change consumes the staged request
			pend_disable_q <= lock_d;
			pend_reenable_q <= 1'b0;
		end
	end

	// ======================================================================
	// rejected key flag, write 1 to clear, a new rejection wins
	reg key_reject_q;
	wire key_bad;

	assign key_bad = wr_key & ~key_ok;

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			key_reject_q <= 1'b0;
		end else if (key_bad) begin
			key_reject_q <= 1'b1;
		end else if (wr_status && wdata_i[`DPL_STAT_KEY_REJECT_BIT]) begin
			key_reject_q <= 1'b0;
		end
	end

	// ======================================================================
	// probe pin synchroniser
	wire probe_sync_q;

	// the pin is asynchronous; nothing reads it before the second stage
	pin_sync probe_pin_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(probe_attach_i),
		.pin_sync_o(probe_sync_q)
	);

	// ======================================================================
	// probe gating, next values follow the lock as it will stand
	reg debug_unit_enable_d;
	reg probe_active_d;
	reg probe_lock_d;

	always @* begin
		debug_unit_enable_d = ~lock_d;
		probe_active_d = probe_sync_q & ~lock_d;
		probe_lock_d = lock_d;
	end

	// an ordinary reset forces the gated side shut even if the lock is open;
	// the lock state is shown again one edge after release
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			debug_unit_enable_o <= 1'b0;
			probe_active_o <= 1'b0;
			probe_lock_o <= 1'b1;
		end else begin
			debug_unit_enable_o <= debug_unit_enable_d;
			probe_active_o <= probe_active_d;
			probe_lock_o <= probe_lock_d;
		end
	end

	// ======================================================================
	// flash reads from the probe
	// refused while either the lock or its gated mirror says locked, so
	// no read slips through in the edge after an ordinary reset
	wire lock_any;

	assign lock_any = lock_q | probe_lock_o;
	assign flash_rd_grant_o = flash_rd_req_i & ~lock_any;
	assign flash_rd_refuse_o = flash_rd_req_i & lock_any;

	// ======================================================================
	// read data, one cycle after the strobe
	// the data stand for that one cycle only and read zero otherwise
	reg [31:0] rdata_d;

	always @* begin
		rdata_d = `DPL_READ_ZERO;
		if (hit_mode) begin
			rdata_d[`DPL_MODE_DISABLE_BIT] = lock_q;
		end else if (hit_status) begin
			rdata_d[`DPL_STAT_PEND_DISABLE_BIT] = pend_disable_q;
			rdata_d[`DPL_STAT_PEND_REENABLE_BIT] = pend_reenable_q;
			rdata_d[`DPL_STAT_KEY_REJECT_BIT] = key_reject_q;
			rdata_d[`DPL_STAT_PROBE_SEEN_BIT] = probe_sync_q;
		end
		// key register and unmapped addresses read zero
	end

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= `DPL_READ_ZERO;
		end else if (rd_i) begin
			rdata_o <= rdata_d;
		end else begin
			rdata_o <= `DPL_READ_ZERO;
		end
	end

endmodule

// ==========================================================================
// two-stage synchroniser for a pin from outside the clock domain
module pin_sync (
	// clock and reset
	input wire core_clk_i,
	input wire rst_n_i,
	// pin and its synchronised copy
	input wire pin_i,
	output reg pin_sync_o
);

	reg meta_q;

	// only the second stage may be read by other logic
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			pin_sync_o <= 1'b0;
		end else begin
			meta_q <= pin_i;
			pin_sync_o <= meta_q;
		end
	end

endmodule

// >>> logic/debug_probe_lock_map.vh
// register map, field positions and constants of the debug probe lock
`ifndef DEBUG_PROBE_LOCK_MAP_VH
`define DEBUG_PROBE_LOCK_MAP_VH

// ==========================================================================
// register byte addresses
`define DPL_ADDR_MODE 32'hffffe510
`define DPL_ADDR_KEY 32'hffffe514
`define DPL_ADDR_STATUS 32'hffffe518

// ==========================================================================
// mode register fields
`define DPL_MODE_DISABLE_BIT 0
`define DPL_MODE_REENABLE_BIT 1
`define DPL_MODE_RESET 1'h1

// ==========================================================================
// status register fields
`define DPL_STAT_PEND_DISABLE_BIT 0
`define DPL_STAT_PEND_REENABLE_BIT 1
`define DPL_STAT_KEY_REJECT_BIT 2
`define DPL_STAT_PROBE_SEEN_BIT 3

// ==========================================================================
// protect code and read values
`define DPL_PROTECT_CODE 32'h000000c5
`define DPL_READ_ZERO 32'h00000000

`endif

// >>> verification/debug_probe_lock_bench.sv
// self-checking bench for the debug probe lock
`timescale 1ns/1ps
`include "debug_probe_lock_map.vh"
module debug_probe_lock_bench;
	logic core_clk_i = 1'h0, rst_n_i = 1'h0, por_n_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, want = 1'h0;
	logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o;
	logic probe_attach_i, flash_rd_req_i, flash_rd_grant_o, flash_rd_refuse_o;
	logic debug_unit_enable_o, probe_active_o, probe_lock_o;
	int errors = 0, n_tests = 0;
	// key select, write data, lock expected after the write
	logic [33:0] rows [7] = '{{1'h0, 32'h0, 1'h1}, {1'h1, 32'hc4, 1'h1}, {1'h1, 32'hc5, 1'h0},
		{1'h0, 32'h2, 1'h0}, {1'h1, 32'h1c5, 1'h0}, {1'h1, 32'hc5, 1'h1}, {1'h1, 32'hc5, 1'h1}};
	debug_probe_lock dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.probe_attach_i(probe_attach_i), .flash_rd_req_i(flash_rd_req_i),
		.flash_rd_grant_o(flash_rd_grant_o), .flash_rd_refuse_o(flash_rd_refuse_o),
		.debug_unit_enable_o(debug_unit_enable_o), .probe_active_o(probe_active_o),
		.probe_lock_o(probe_lock_o));
	probe_model pm (.core_clk_i(core_clk_i), .want_i(want), .attach_o(probe_attach_i),
		.flash_rd_req_o(flash_rd_req_i));
	initial forever #2 core_clk_i = ~core_clk_i;
	task chk(input string name, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one full-word access; read data are settled on return
	task bus(input logic w, input logic [31:0] a, d);
		@(posedge core_clk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'h0;
		rd_i <= 1'h0;
		#1;
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		por_n_i <= 1'h1;
		want <= 1'h1;
		for (int i = 0; i < 7; i++) begin
			bus(1'h1, rows[i][33] ? `DPL_ADDR_KEY : `DPL_ADDR_MODE, rows[i][32:1]);
			chk("lock", probe_lock_o, rows[i][0]);
			chk("refuse", flash_rd_refuse_o, rows[i][0]);
			chk("grant", flash_rd_grant_o, !rows[i][0]);
			chk("unit enable", debug_unit_enable_o, !rows[i][0]);
			chk("probe active", probe_active_o, !rows[i][0]);
		end
		bus(1'h0, `DPL_ADDR_MODE, 32'h0);
		chk("mode read", rdata_o, 32'h1);
		bus(1'h0, `DPL_ADDR_KEY, 32'h0);
		chk("key read", rdata_o, 32'h0);
		@(posedge core_clk_i);
		#1 chk("read idle", rdata_o, 32'h0);
		bus(1'h0, `DPL_ADDR_STATUS, 32'h0);
		chk("status", rdata_o, 32'hd);
		bus(1'h1, `DPL_ADDR_STATUS, 32'h4);
		bus(1'h0, `DPL_ADDR_STATUS, 32'h0);
		chk("status cleared", rdata_o, 32'h9);
		bus(1'h1, `DPL_ADDR_MODE, 32'h0);
		bus(1'h1, `DPL_ADDR_KEY, `DPL_PROTECT_CODE);
		@(posedge core_clk_i);
		rst_n_i <= 1'h0;
		repeat (2) @(posedge core_clk_i);
		#1 chk("unit in reset", debug_unit_enable_o, 32'h0);
		chk("refuse in reset", flash_rd_refuse_o, 32'h1);
		@(posedge core_clk_i);
		rst_n_i <= 1'h1;
		repeat (2) @(posedge core_clk_i);
		#1 chk("lock after reset", probe_lock_o, 32'h0);
		@(posedge core_clk_i);
		por_n_i <= 1'h0;
		rst_n_i <= 1'h0;
		repeat (2) @(posedge core_clk_i);
		por_n_i <= 1'h1;
		rst_n_i <= 1'h1;
		repeat (2) @(posedge core_clk_i);
		#1 chk("lock after power-on", probe_lock_o, 32'h1);
		close_out;
	end
endmodule
bind debug_probe_lock lock_checker chk_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.por_n_i(por_n_i), .wr_i(wr_i), .rd_i(rd_i), .probe_attach_i(probe_attach_i),
	.flash_rd_req_i(flash_rd_req_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
	.flash_rd_grant_o(flash_rd_grant_o), .flash_rd_refuse_o(flash_rd_refuse_o),
	.debug_unit_enable_o(debug_unit_enable_o), .probe_active_o(probe_active_o),
	.probe_lock_o(probe_lock_o));

// >>> verification/lock_checker_properties.sv
// assertions on the debug probe lock ports
`timescale 1ns/1ps
`include "debug_probe_lock_map.vh"
module lock_checker (
	input wire core_clk_i, rst_n_i, por_n_i, wr_i, rd_i, probe_attach_i, flash_rd_req_i,
	input wire [31:0] addr_i, wdata_i, rdata_o,
	input wire flash_rd_grant_o, flash_rd_refuse_o, debug_unit_enable_o,
	input wire probe_active_o, probe_lock_o
);
	wire key_w = wr_i && addr_i == `DPL_ADDR_KEY;
	wire key_ok = key_w && wdata_i == `DPL_PROTECT_CODE;
	reg held_q;
	// lock as it stood before an ordinary reset
	always @(posedge core_clk_i or negedge por_n_i)
		if (!por_n_i) held_q <= 1'h1;
		else if (rst_n_i) held_q <= probe_lock_o;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i || !por_n_i);
	flash_refuse_a: assert property (flash_rd_req_i && probe_lock_o
		|-> flash_rd_refuse_o && !flash_rd_grant_o) else $error("read not refused");
	unit_gate_a: assert property (probe_lock_o
		|-> !debug_unit_enable_o && !probe_active_o) else $error("unit not gated");
	unlock_key_a: assert property ($fell(probe_lock_o) && $past(rst_n_i, 2)
		|-> $past(key_ok)) else $error("unlock without key");
	relock_key_a: assert property ($rose(probe_lock_o) && $past(rst_n_i, 2)
		|-> $past(key_ok)) else $error("relock without key");
	bad_key_a: assert property (key_w && !key_ok |=> $stable(probe_lock_o))
		else $error("wrong key took effect");
	key_read_a: assert property (rd_i && addr_i == `DPL_ADDR_KEY |=> rdata_o == 32'h0)
		else $error("key readable");
	mode_word_a: assert property (rd_i && addr_i == `DPL_ADDR_MODE
		|=> rdata_o == {31'h0, $past(probe_lock_o)}) else $error("mode read wrong");
	por_lock_a: assert property ($rose(por_n_i) |-> probe_lock_o ##1 probe_lock_o)
		else $error("not locked after power-on");
	lock_persist_a: assert property ($rose(rst_n_i) |=> probe_lock_o == $past(held_q))
		else $error("lock lost in reset");
	read_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not idle");
endmodule

// >>> verification/probe_model.sv
// far-side stand-in: a probe that asks for flash reads while attached
`timescale 1ns/1ps
module probe_model (
	input wire core_clk_i,
	input wire want_i,
	output reg attach_o = 1'h0,
	output reg flash_rd_req_o = 1'h0
);
	always @(posedge core_clk_i) begin
		attach_o <= want_i;
		flash_rd_req_o <= attach_o;
	end
endmodule
